// >>> logic/rbcs_pkg.sv
`default_nettype none
package rbcs_pkg;

    // ****************************************
    // Reset sources
    // ****************************************
    localparam int SRC_N = 8;
    localparam int SRC_POR = 0;
    localparam int SRC_PIN = 1;
    localparam int SRC_CMP = 2;
    localparam int SRC_SW = 3;
    localparam int SRC_SMON = 4;
    localparam int SRC_WDT = 5;
    localparam int SRC_MCD = 6;
    localparam int SRC_FLASH = 7;

    // ****************************************
    // Clock selection and divider
    // ****************************************
    typedef enum logic [1:0] {
        CLK_FAST,
        CLK_SLOW,
        CLK_EXT
    } rbcs_clk_src_t;

    typedef struct packed {
        rbcs_clk_src_t sel;
        logic [2:0] div_log2;
    } rbcs_clk_cfg_t;

    localparam logic [2:0] DIV_LOG2_RESET = 3'h3;
    localparam rbcs_clk_cfg_t CLK_CFG_RESET = '{sel: CLK_FAST,
                                                div_log2: DIV_LOG2_RESET};
    localparam int DIV_CNT_W = 7;

    // ****************************************
    // Boot vector selection
    // ****************************************
    localparam logic [15:0] LOCK_BYTE_ADDR = 16'h1FFF;
    localparam logic [15:0] SIG_ADDR = LOCK_BYTE_ADDR - 16'h0001;
    localparam logic [7:0] SIG_PRESENT = 8'hA5;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] SEC_PAGE_BASE = 16'h1E00;
    localparam logic [15:0] BOOT_VECTOR = SEC_PAGE_BASE;

    // ****************************************
    // Sequencer and port control
    // ****************************************
    typedef enum logic [1:0] {
        SEQ_RESET,
        SEQ_SIG_REQ,
        SEQ_SIG_WAIT,
        SEQ_RUN
    } rbcs_seq_t;

    typedef struct packed {
        logic force_latch_one;
        logic force_open_drain;
        logic weak_pullup_en;
    } rbcs_port_ctl_t;

endpackage
`default_nettype wire

// >>> logic/rbcs_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module rbcs_clk_div
    import rbcs_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic reset, // Sync reset, active high
    input wire logic [2:0] src_tick, // Edge pulses: fast, slow, ext
    input wire rbcs_clk_cfg_t cfg, // Selected source and ratio
    output logic sys_tick // One pulse per divided clock
);

    typedef struct packed {
        logic [DIV_CNT_W-1:0] cnt;
        logic tick;
    } rbcs_div_state_t;

    rbcs_div_state_t s_q, s_d;
    logic src_sel;
    logic [DIV_CNT_W-1:0] mask;

    // ****************************************
    // Divide the selected source by 2^n
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        // Unused selector code falls back to the fast oscillator
        unique case (cfg.sel)
            CLK_SLOW: src_sel = src_tick[1]; // RULE_03
            CLK_EXT: src_sel = src_tick[2];
            default: src_sel = src_tick[0];
        endcase
        mask = DIV_CNT_W'((8'h01 << cfg.div_log2) - 8'h01); // RULE_02
        if (src_sel) begin
            if ((s_q.cnt & mask) == mask) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + DIV_CNT_W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sys_tick = s_q.tick;

    a_div_ratio: assert property (@(posedge clk_sys) // RULE_02
        disable iff (reset)
        (src_sel && ((s_q.cnt & mask) == mask)) |=> sys_tick)
        else $error("divider missed its terminal count");

endmodule // rbcs_clk_div
`default_nettype wire

// >>> logic/rbcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE_01) Exit reset on fast oscillator, divide 8
// (RULE_02) Divider offers ratios 1 to 128
// (RULE_03) Select fast, slow or external clock
// (RULE_04) Reset halts core, interrupts, timers
// (RULE_05) Reset defaults except power-on-only bits
// (RULE_06) Data RAM untouched by reset
// (RULE_07) Ports forced high open-drain, pull-ups on
// (RULE_08) Power-on/supply resets drive pin low
// (RULE_09) Exit clears PC, internal clock, watchdog
// (RULE_10) Eight reset sources
// (RULE_11) Signature byte 0xA5 means bootloader present
// (RULE_12) Bootloader present: start at boot vector
// (RULE_13) No bootloader: start at address zero
// (RULE_14) Bootloader in last, erasable flash page
// (RULE_15) Synchronise sources, hold until all release
module rbcs_sequencer
    import rbcs_pkg::*;
(
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic reset, // Sync reset, active high
    input wire logic por_req, // Power-on detector, high active
    input wire logic reset_pin_n_in, // External reset pin level
    input wire logic cmp_reset_req, // Comparator reset
    input wire logic sw_reset_req, // Software reset
    input wire logic smon_reset_req, // Supply monitor reset
    input wire logic wdt_reset_req, // Watchdog reset
    input wire logic mcd_reset_req, // Missing clock detector
    input wire logic flash_err_req, // Flash error reset
    input wire logic fast_internal_osc, // Fast oscillator edge pulse
    input wire logic slow_internal_osc, // Slow oscillator edge pulse
    input wire logic external_cmos_clock_in, // External clock edge pulse
    input wire logic clk_cfg_load, // Core strobe for new clock config
    input wire rbcs_clk_cfg_t clk_cfg_in, // New clock config
    input wire logic flash_rd_valid, // Flash read data valid
    input wire logic [7:0] flash_rd_data, // Flash read data
    output logic flash_rd_req, // Flash read request, held
    output logic [15:0] flash_rd_addr, // Flash read address
    output logic core_halt, // Core stopped
    output logic irq_disable, // All interrupts off
    output logic timer_disable, // All timers off
    output logic sys_rst, // Reset to ordinary register bits
    output logic por_rst, // Reset to power-on-only bits
    output logic pc_load, // One pulse: load start vector
    output logic [15:0] start_vector, // First fetch address
    output logic wdt_enable, // Watchdog enable
    output rbcs_clk_cfg_t clk_cfg, // Active clock config
    output logic sys_tick, // Divided system clock pulse
    output logic [SRC_N-1:0] reset_cause, // Latched reset causes
    output rbcs_port_ctl_t port_ctl, // Port pin forcing
    output logic reset_pin_n_out, // Reset pin drive value
    output logic reset_pin_n_oe, // Reset pin drive enable
    output logic [15:0] boot_page_base, // Security page start
    output logic boot_page_erasable // Security page may be erased
);

    typedef struct packed {
        rbcs_seq_t seq;
        logic [SRC_N-1:0] sync1;
        logic [SRC_N-1:0] sync2;
        logic [SRC_N-1:0] cause;
        logic drive_pin;
        rbcs_clk_cfg_t clk;
        logic [15:0] vector;
        logic pc_load;
        logic wdt_en;
        logic rd_req;
    } rbcs_state_t;

    localparam rbcs_state_t STATE_RESET = '{seq: SEQ_RESET,
        sync1: '0, sync2: '0, cause: '0, drive_pin: 1'b1,
        clk: CLK_CFG_RESET, vector: RESET_VECTOR, pc_load: 1'b0,
        wdt_en: 1'b1, rd_req: 1'b0};

    rbcs_state_t s_q, s_d;
    logic [SRC_N-1:0] raw_src;
    logic any_src;

    // ****************************************
    // Reset source collection
    // ****************************************
    always_comb begin
        raw_src = '0;
        raw_src[SRC_POR] = por_req; // RULE_10
        raw_src[SRC_PIN] = ~reset_pin_n_in;
        raw_src[SRC_CMP] = cmp_reset_req;
        raw_src[SRC_SW] = sw_reset_req;
        raw_src[SRC_SMON] = smon_reset_req;
        raw_src[SRC_WDT] = wdt_reset_req;
        raw_src[SRC_MCD] = mcd_reset_req;
        raw_src[SRC_FLASH] = flash_err_req;
    end

    assign any_src = |s_q.sync2;

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        // Sources are async; second stage is the only reader
        s_d.sync1 = raw_src; // RULE_15
        s_d.sync2 = s_q.sync1;
        s_d.pc_load = 1'b0;
        s_d.rd_req = 1'b0;
        // Cause bits survive all but power-on; set wins
        if (s_q.sync2[SRC_POR]) begin
            s_d.cause = s_q.sync2; // RULE_05
        end else begin
            s_d.cause = s_q.cause | s_q.sync2;
        end
        if (s_q.sync2[SRC_POR] || s_q.sync2[SRC_SMON]) begin
            s_d.drive_pin = 1'b1; // RULE_08
        end
        if (any_src) begin
            // Any active source restarts; stays until all released
            s_d.seq = SEQ_RESET; // RULE_15
        end else begin
            unique case (s_q.seq)
                SEQ_RESET: begin
                    s_d.seq = SEQ_SIG_REQ;
                end
                SEQ_SIG_REQ: begin
                    s_d.rd_req = 1'b1;
                    s_d.seq = SEQ_SIG_WAIT;
                end
                SEQ_SIG_WAIT: begin
                    s_d.rd_req = 1'b1;
                    if (flash_rd_valid) begin
                        s_d.rd_req = 1'b0;
                        if (flash_rd_data == SIG_PRESENT) begin // RULE_11
                            s_d.vector = BOOT_VECTOR; // RULE_12
                        end else begin
                            s_d.vector = RESET_VECTOR; // RULE_13
                        end
                        s_d.pc_load = 1'b1; // RULE_09
                        s_d.drive_pin = 1'b0;
                        s_d.seq = SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    // Reserved selector code is refused
                    if (clk_cfg_load && clk_cfg_in.sel != 2'h3) begin
                        s_d.clk = clk_cfg_in; // RULE_03
                    end
                end
            endcase
        end
        // Whole reset phase keeps default clock and watchdog on
        if (s_d.seq != SEQ_RUN) begin
            s_d.clk = CLK_CFG_RESET; // RULE_01
            s_d.wdt_en = 1'b1; // RULE_09
        end
    end

    // State register; data RAM lives outside and is never cleared here
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= STATE_RESET; // RULE_06
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Clock divider
    // ****************************************
    rbcs_clk_div u_div (
        .clk_sys(clk_sys),
        .reset(reset),
        .src_tick({external_cmos_clock_in, slow_internal_osc,
                   fast_internal_osc}),
        .cfg(s_q.clk),
        .sys_tick(sys_tick)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign core_halt = (s_q.seq != SEQ_RUN); // RULE_04
    assign irq_disable = core_halt;
    assign timer_disable = core_halt;
    assign sys_rst = core_halt; // RULE_05
    assign por_rst = s_q.sync2[SRC_POR];
    assign flash_rd_req = s_q.rd_req;
    assign flash_rd_addr = SIG_ADDR;
    assign pc_load = s_q.pc_load;
    assign start_vector = s_q.vector;
    assign wdt_enable = s_q.wdt_en;
    assign clk_cfg = s_q.clk;
    assign reset_cause = s_q.cause;
    // Pull-ups stay on after reset too; no input turns them off
    assign port_ctl.force_latch_one = core_halt; // RULE_07
    assign port_ctl.force_open_drain = core_halt;
    assign port_ctl.weak_pullup_en = 1'b1;
    // Open-drain: only ever pulls low
    assign reset_pin_n_out = 1'b0;
    assign reset_pin_n_oe = s_q.drive_pin; // RULE_08
    assign boot_page_base = SEC_PAGE_BASE; // RULE_14
    assign boot_page_erasable = 1'b1;

    // ****************************************
    // Checks
    // ****************************************
    a_clk_default: assert property (@(posedge clk_sys) // RULE_01
        disable iff (reset)
        pc_load |-> (clk_cfg == CLK_CFG_RESET))
        else $error("reset exit without default clock");

    a_clk_select: assert property (@(posedge clk_sys) // RULE_03
        disable iff (reset)
        (s_q.seq == SEQ_RUN && !any_src && clk_cfg_load
         && clk_cfg_in.sel != 2'h3) |=> (clk_cfg == $past(clk_cfg_in)))
        else $error("clock config not applied");

    a_halt_hold: assert property (@(posedge clk_sys) // RULE_04
        disable iff (reset)
        any_src |=> (core_halt && irq_disable && timer_disable))
        else $error("core not halted during reset");

    a_cause_keep: assert property (@(posedge clk_sys) // RULE_05
        disable iff (reset)
        !s_q.sync2[SRC_POR] |=> ((reset_cause & $past(reset_cause))
                                 == $past(reset_cause)))
        else $error("power-on-only bits lost");

    a_port_force: assert property (@(posedge clk_sys) // RULE_07
        disable iff (reset)
        core_halt |-> (port_ctl.force_latch_one && port_ctl.force_open_drain
                       && port_ctl.weak_pullup_en))
        else $error("ports not forced during reset");

    a_pin_drive: assert property (@(posedge clk_sys) // RULE_08
        disable iff (reset)
        (s_q.sync2[SRC_POR] || s_q.sync2[SRC_SMON]) |=> reset_pin_n_oe)
        else $error("reset pin not driven");

    // Pin may only let go together with the start pulse
    a_pin_hold: assert property (@(posedge clk_sys) // RULE_08
        disable iff (reset)
        $fell(reset_pin_n_oe) |-> pc_load)
        else $error("reset pin released early");

    a_exit_load: assert property (@(posedge clk_sys) // RULE_09
        disable iff (reset)
        pc_load |-> (wdt_enable && $past(s_q.seq) == SEQ_SIG_WAIT
                     && !core_halt && !reset_pin_n_oe))
        else $error("bad reset exit");

    a_src_entry: assert property (@(posedge clk_sys) // RULE_10
        disable iff (reset)
        (|raw_src) |-> ##3 core_halt)
        else $error("reset source not seen in three cycles");

    a_vector_pick: assert property (@(posedge clk_sys) // RULE_12
        disable iff (reset)
        (s_q.seq == SEQ_SIG_WAIT && flash_rd_valid && !any_src) |=>
            (pc_load && start_vector == (($past(flash_rd_data) == SIG_PRESENT)
                                         ? BOOT_VECTOR : RESET_VECTOR)))
        else $error("wrong start vector");

    a_hold_release: assert property (@(posedge clk_sys) // RULE_15
        disable iff (reset)
        any_src |=> (s_q.seq == SEQ_RESET))
        else $error("left reset while a source active");

endmodule // rbcs_sequencer
`default_nettype wire

// >>> tb/rbcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Flash controller holding the signature byte
// ****************************************
module rbcs_flash_model
    import rbcs_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic flash_rd_req, // Read request, held
    input wire logic [15:0] flash_rd_addr, // Read address
    input wire logic [7:0] sig_byte, // Stored signature byte
    input wire logic [3:0] wait_cycles, // Answer latency
    output logic flash_rd_valid, // One-cycle data strobe
    output logic [7:0] flash_rd_data // Read data
);
    logic [3:0] cnt_q;

    initial begin
        flash_rd_valid = 1'b0;
        flash_rd_data = 8'h00;
        cnt_q = 4'h0;
    end

    // Answer after a chosen wait; data bus toggles when not valid
    always @(posedge clk_sys) begin
        if (flash_rd_valid) begin
            flash_rd_valid <= 1'b0;
            flash_rd_data <= ~flash_rd_data; // No stale byte left behind
            cnt_q <= 4'h0;
        end else if (flash_rd_req && cnt_q >= wait_cycles) begin
            flash_rd_valid <= 1'b1;
            // Erased flash reads all ones off the signature place
            flash_rd_data <= (flash_rd_addr == SIG_ADDR) ? sig_byte
                                                         : 8'hFF;
        end else begin
            if (flash_rd_req) begin
                cnt_q <= cnt_q + 4'h1;
            end
            flash_rd_data <= ~flash_rd_data;
        end
    end
endmodule // rbcs_flash_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rbcs_pkg::*;
    logic clk_sys, reset, por_req, reset_pin_n_in, cmp_reset_req, sw_reset_req;
    logic smon_reset_req, wdt_reset_req, mcd_reset_req, flash_err_req;
    logic fast_osc, slow_osc, ext_osc, clk_cfg_load, flash_rd_valid;
    logic flash_rd_req, core_halt, irq_disable, timer_disable, sys_rst;
    logic por_rst, pc_load, wdt_enable, sys_tick, reset_pin_n_out;
    logic reset_pin_n_oe, boot_page_erasable;
    logic [7:0] flash_rd_data, reset_cause, sig_byte;
    logic [15:0] flash_rd_addr, start_vector, boot_page_base;
    logic [3:0] wait_cycles;
    rbcs_clk_cfg_t clk_cfg_in, clk_cfg;
    rbcs_port_ctl_t port_ctl;
    int failures = 0, n_checks = 0, ticks = 0;

    rbcs_sequencer DUT (.clk_sys(clk_sys), .reset(reset), .por_req(por_req),
        .reset_pin_n_in(reset_pin_n_in), .cmp_reset_req(cmp_reset_req),
        .sw_reset_req(sw_reset_req), .smon_reset_req(smon_reset_req),
        .wdt_reset_req(wdt_reset_req), .mcd_reset_req(mcd_reset_req),
        .flash_err_req(flash_err_req), .fast_internal_osc(fast_osc),
        .slow_internal_osc(slow_osc), .external_cmos_clock_in(ext_osc),
        .clk_cfg_load(clk_cfg_load), .clk_cfg_in(clk_cfg_in),
        .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
        .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
        .core_halt(core_halt), .irq_disable(irq_disable),
        .timer_disable(timer_disable), .sys_rst(sys_rst), .por_rst(por_rst),
        .pc_load(pc_load), .start_vector(start_vector),
        .wdt_enable(wdt_enable), .clk_cfg(clk_cfg), .sys_tick(sys_tick),
        .reset_cause(reset_cause), .port_ctl(port_ctl),
        .reset_pin_n_out(reset_pin_n_out), .reset_pin_n_oe(reset_pin_n_oe),
        .boot_page_base(boot_page_base),
        .boot_page_erasable(boot_page_erasable));
    rbcs_flash_model flash (.clk_sys(clk_sys), .flash_rd_req(flash_rd_req),
        .flash_rd_addr(flash_rd_addr), .sig_byte(sig_byte),
        .wait_cycles(wait_cycles), .flash_rd_valid(flash_rd_valid),
        .flash_rd_data(flash_rd_data));

    // ****************************************
    // Clock, tick monitor and shared tasks
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (sys_tick === 1'b1) ticks++;

    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Pin source is active low, the rest active high
    task automatic set_src(int i, logic v);
        case (i)
            0: por_req = v;
            1: reset_pin_n_in = !v;
            2: cmp_reset_req = v;
            3: sw_reset_req = v;
            4: smon_reset_req = v;
            5: wdt_reset_req = v;
            6: mcd_reset_req = v;
            default: flash_err_req = v;
        endcase
    endtask
    // Bounded wait for the start pulse, then the run-state outputs
    task automatic wait_boot(logic [15:0] vec);
        int k = 0;
        while (pc_load !== 1'b1 && k < 60) begin
            tick();
            k++;
        end
        check("pc_load", 1, pc_load);
        check("start_vector", vec, start_vector);
        check("halt_irq", 0, {core_halt, irq_disable});
        check("tmr_rst", 0, {timer_disable, sys_rst});
        check("pin_oe", 0, reset_pin_n_oe);
        check("clk_cfg", CLK_CFG_RESET, clk_cfg);
        check("wdt_enable", 1, wdt_enable);
        check("pullup", 1, port_ctl.weak_pullup_en);
        tick();
        check("pc_pulse", 0, pc_load);
    endtask
    task automatic load_cfg(rbcs_clk_src_t s, logic [2:0] d);
        clk_cfg_in = '{sel: s, div_log2: d};
        clk_cfg_load = 1'b1;
        tick();
        clk_cfg_load = 1'b0;
        // Gap so that a following load never re-raises the strobe at once
        tick();
    endtask
    // Pulses on the chosen sources: bit 0 fast, 1 slow, 2 external
    task automatic pulse_osc(int n, logic [2:0] which);
        repeat (n) begin
            {ext_osc, slow_osc, fast_osc} = which;
            tick();
            {ext_osc, slow_osc, fast_osc} = 3'h0;
            tick();
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_each_source();
        for (int i = 0; i < SRC_N; i++) begin
            wait_cycles = 4'(i);
            sig_byte = (i % 2 == 0) ? 8'hA5 : 8'hA4;
            set_src(i, 1'b1);
            tick(3);
            check("halt_irq", 2'h3, {core_halt, irq_disable});
            check("tmr_rst", 2'h3, {timer_disable, sys_rst});
            check("cause", 1, reset_cause[i]);
            check("pin_oe", (i == 0 || i == 4), reset_pin_n_oe);
            check("pin_out", 0, reset_pin_n_out);
            check("port_ctl", 3'h7, port_ctl);
            if (i == 0) check("por_rst", 1, por_rst);
            // Power-on wipes older causes; other resets keep them
            if (i == 0) check("por_clears", 8'h01, reset_cause);
            else check("cause_kept", 1, reset_cause[0]);
            tick(4);
            check("still_held", 1, core_halt);
            set_src(i, 1'b0);
            wait_boot((i % 2 == 0) ? BOOT_VECTOR : RESET_VECTOR);
        end
    endtask
    task automatic t_overlap();
        sig_byte = SIG_PRESENT;
        cmp_reset_req = 1'b1;
        wdt_reset_req = 1'b1;
        tick(3);
        cmp_reset_req = 1'b0;
        tick(6);
        check("overlap_halt", 1, core_halt);
        check("no_read", 0, flash_rd_req);
        wdt_reset_req = 1'b0;
        wait_boot(BOOT_VECTOR);
    endtask
    task automatic t_clock();
        load_cfg(CLK_SLOW, 3'h0);
        check("cfg_slow", {CLK_SLOW, 3'h0}, clk_cfg);
        ticks = 0;
        pulse_osc(4, 3'h1);
        check("slow_ignores_fast", 0, 16'(ticks));
        pulse_osc(3, 3'h2);
        check("slow_ticks", 3, 16'(ticks));
        load_cfg(CLK_EXT, 3'h5);
        check("cfg_ext", {CLK_EXT, 3'h5}, clk_cfg);
        ticks = 0;
        pulse_osc(32, 3'h4);
        check("ext_ticks", 1, 16'(ticks));
        load_cfg(rbcs_clk_src_t'(2'h3), 3'h0);
        check("cfg_refused", {CLK_EXT, 3'h5}, clk_cfg);
        for (int n = 0; n < 8; n++) begin
            load_cfg(CLK_FAST, 3'(n));
            tick(3);
            ticks = 0;
            pulse_osc(2 << n, 3'h1);
            tick(3);
            check("ticks_per_ratio", 2, 16'(ticks));
        end
        sw_reset_req = 1'b1;
        tick(3);
        sw_reset_req = 1'b0;
        wait_boot(BOOT_VECTOR);
    endtask

    // Watchdog sized well beyond the scenario run
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    initial begin
        {reset, por_req, cmp_reset_req, sw_reset_req, smon_reset_req} = 5'h10;
        {wdt_reset_req, mcd_reset_req, flash_err_req, fast_osc} = 4'h0;
        {slow_osc, ext_osc, clk_cfg_load, reset_pin_n_in} = 4'h1;
        clk_cfg_in = CLK_CFG_RESET;
        sig_byte = 8'hA5;
        wait_cycles = 4'h2;
        tick(12);
        check("cfg_in_reset", CLK_CFG_RESET, clk_cfg);
        check("cause_clear", 0, reset_cause);
        check("page_base", 16'h1E00, boot_page_base);
        check("page_erasable", 1, boot_page_erasable);
        reset = 1'b0;
        wait_boot(BOOT_VECTOR);
        check("rd_addr", SIG_ADDR, flash_rd_addr);
        t_clock();
        t_each_source();
        t_overlap();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
